// ==== hw/scrm_top.sv ====
// Overview of operation
// - Ratio above four keeps fast clocks running
// - External reset in shutdown logs power-on
// - Mask ineffective when detector off, monitor, debug in shutdown
// - Failure flag may set at disable; RC fallback
// - Idle/frozen wake gates other peripheral clocks
// - External-mode oscillator makes wake exit unstable
`timescale 1ns/1ps
`default_nettype none
module scrm_top #(
   parameter int N_PB = 4
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Reset and sleep events
   input wire logic i_ext_rst_evt,
   input wire logic i_por_evt,
   input wire logic i_wake,
   input wire logic i_debug_attached,
   input wire logic i_clock_fail,
   input wire logic [N_PB-1:0] i_pb_walk_req,
   // Outputs
   output logic o_hs_clk_on,
   output logic o_main_osc_on,
   output logic o_sel_system_rc_oscillator,
   output logic o_por_reset,
   output logic [N_PB-1:0] o_pb_clk_en,
   output logic o_walk_unstable
);
   if (N_PB < 1 || N_PB > 8) begin : g_bad_n_pb
      $error("N_PB must be 1..8");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] div_q, div_d;
   logic [1:0] osc_q, osc_d;
   logic [N_PB-1:0] ppcr_q, ppcr_d;
   logic cfd_flag_q, cfd_flag_d;
   logic [7:0] cause_q, cause_d;
   scrm_pkg::scrm_mode_t mode_q, mode_d;
   logic [7:0] rdata_q, rdata_d;
   logic hs_on_q, hs_on_d;
   logic osc_on_q, osc_on_d;
   logic por_q, por_d;
   logic unstable_q, unstable_d;
   logic osc_auto_off_q, osc_auto_off_d;

   logic [scrm_pkg::DIV_W-1:0] hsb_div, pb_div;
   logic ratio_big;
   logic rc_stop;
   logic walking;
   // Wake activity in any sleep mode
   logic walk_any;
   logic cfd_off_write;
   logic mask_bad;
   logic sleeping;

   scrm_pb_if #(.N(N_PB)) pb ();

   always_comb begin
      hsb_div = div_q[2:0];
      pb_div = div_q[6:4];
      ratio_big = (pb_div > hsb_div) &&
         ((pb_div - hsb_div) > scrm_pkg::DIV_RATIO_MAX);
      sleeping = (mode_q != scrm_pkg::SM_RUN);
      rc_stop = (mode_q == scrm_pkg::SM_STATIC) ||
         (mode_q == scrm_pkg::SM_SHUTDOWN);
      walking = ((mode_q == scrm_pkg::SM_IDLE) ||
         (mode_q == scrm_pkg::SM_FROZEN)) &&
         |(i_pb_walk_req & ~ppcr_q);
      walk_any = sleeping && |(i_pb_walk_req & ~ppcr_q);
      cfd_off_write = i_wr && (i_addr == scrm_pkg::ADDR_CTRL) &&
         ctrl_q[scrm_pkg::CTRL_CFD_EN] &&
         !i_wdata[scrm_pkg::CTRL_CFD_EN];
      mask_bad = !ctrl_q[scrm_pkg::CTRL_POR_EN] ||
         ctrl_q[scrm_pkg::CTRL_SM_EN] ||
         ((mode_q == scrm_pkg::SM_SHUTDOWN) && i_debug_attached);
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      div_d = div_q;
      osc_d = osc_q;
      ppcr_d = ppcr_q;
      mode_d = mode_q;
      cfd_flag_d = cfd_flag_q;
      cause_d = cause_q;
      rdata_d = 8'h00;
      if (i_wr) begin
         case (i_addr)
            scrm_pkg::ADDR_CTRL: ctrl_d = i_wdata;
            scrm_pkg::ADDR_CLKDIV: div_d = i_wdata & 8'h77;
            scrm_pkg::ADDR_OSC: osc_d = i_wdata[1:0];
            scrm_pkg::ADDR_PPCR: ppcr_d = i_wdata[N_PB-1:0];
            scrm_pkg::ADDR_STATUS: begin
               if (i_wdata[scrm_pkg::ST_CFD]) cfd_flag_d = 1'b0;
            end
            scrm_pkg::ADDR_SLEEP: begin
               if (i_wdata[2:0] <= 3'h5) begin
                  mode_d = scrm_pkg::scrm_mode_t'(i_wdata[2:0]);
               end
            end
            default: ;
         endcase
      end
      if (i_wake) mode_d = scrm_pkg::SM_RUN;
      // Flag also rises as the detector is switched off
      if (i_clock_fail && (ctrl_q[scrm_pkg::CTRL_CFD_EN] ||
            cfd_off_write)) begin
         cfd_flag_d = 1'b1;
      end
      // Failure forces main clock to the RC oscillator
      if (cfd_flag_d) ctrl_d[scrm_pkg::CTRL_MAIN_SEL] = 1'b0;
      if (i_ext_rst_evt) begin
         // Shutdown exit by pin logs as power-on
         if (mode_q == scrm_pkg::SM_SHUTDOWN) begin
            cause_d = scrm_pkg::CAUSE_POR;
         end else begin
            cause_d = scrm_pkg::CAUSE_EXT;
         end
         mode_d = scrm_pkg::SM_RUN;
      end else if (i_wake && mode_q == scrm_pkg::SM_SHUTDOWN) begin
         cause_d = scrm_pkg::CAUSE_SLEEP;
      end
      if (i_rd) begin
         case (i_addr)
            scrm_pkg::ADDR_CTRL: rdata_d = ctrl_q;
            scrm_pkg::ADDR_CLKDIV: rdata_d = div_q;
            scrm_pkg::ADDR_OSC: rdata_d = {6'h00, osc_q};
            scrm_pkg::ADDR_PPCR: rdata_d = 8'(ppcr_q);
            scrm_pkg::ADDR_STATUS: rdata_d = {4'h0, unstable_q,
               osc_on_q, hs_on_q, cfd_flag_q};
            scrm_pkg::ADDR_CAUSE: rdata_d = cause_q;
            scrm_pkg::ADDR_SLEEP: rdata_d = {5'h00, mode_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_comb begin
      // Fast clocks stay on when ratio too large
      hs_on_d = !rc_stop || ratio_big;
      osc_on_d = osc_q[scrm_pkg::OSC_EN] && !(sleeping &&
         mode_q >= scrm_pkg::SM_STANDBY);
      osc_auto_off_d = osc_auto_off_q;
      if (mode_q >= scrm_pkg::SM_STANDBY) osc_auto_off_d = 1'b1;
      else if (mode_q == scrm_pkg::SM_RUN) osc_auto_off_d = 1'b0;
      // External-mode oscillator flags unstable wake exit
      unstable_d = unstable_q;
      if (osc_q[scrm_pkg::OSC_EN] && osc_auto_off_q && walk_any &&
            osc_q[scrm_pkg::OSC_MODE] == scrm_pkg::OSC_MODE_EXT) begin
         unstable_d = 1'b1;
      end else if (i_wr && i_addr == scrm_pkg::ADDR_STATUS &&
            i_wdata[scrm_pkg::ST_UNSTABLE]) begin
         unstable_d = 1'b0;
      end
      // Mask works only outside the faulty cases
      por_d = i_por_evt && !(ctrl_q[scrm_pkg::CTRL_POR_MASK] && !mask_bad);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ctrl_q <= scrm_pkg::CTRL_RST;
         div_q <= 8'h00;
         osc_q <= 2'h0;
         ppcr_q <= '0;
         mode_q <= scrm_pkg::SM_RUN;
         cfd_flag_q <= 1'b0;
         cause_q <= scrm_pkg::CAUSE_POR;
         rdata_q <= 8'h00;
         hs_on_q <= 1'b1;
         osc_on_q <= 1'b0;
         por_q <= 1'b0;
         unstable_q <= 1'b0;
         osc_auto_off_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         div_q <= div_d;
         osc_q <= osc_d;
         ppcr_q <= ppcr_d;
         mode_q <= mode_d;
         cfd_flag_q <= cfd_flag_d;
         cause_q <= cause_d;
         rdata_q <= rdata_d;
         hs_on_q <= hs_on_d;
         osc_on_q <= osc_on_d;
         por_q <= por_d;
         unstable_q <= unstable_d;
         osc_auto_off_q <= osc_auto_off_d;
      end
   end

   // ------------------------------------------------------------
   // Peripheral clock gating
   // ------------------------------------------------------------
   assign pb.req = i_pb_walk_req;
   assign pb.mask = ppcr_q;
   assign pb.walk_gate = walking;

   scrm_pb_gate #(.N(N_PB)) u_gate (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .pb(pb.gate)
   );

   assign o_rdata = rdata_q;
   assign o_hs_clk_on = hs_on_q;
   assign o_main_osc_on = osc_on_q;
   assign o_sel_system_rc_oscillator = !ctrl_q[scrm_pkg::CTRL_MAIN_SEL];
   assign o_por_reset = por_q;
   assign o_pb_clk_en = pb.en;
   assign o_walk_unstable = unstable_q;
endmodule
`default_nettype wire

// ==== hw/scrm_pkg.sv ====
package scrm_pkg;
   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CLKDIV = 4'h1;
   localparam logic [3:0] ADDR_OSC = 4'h2;
   localparam logic [3:0] ADDR_PPCR = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CAUSE = 4'h5;
   localparam logic [3:0] ADDR_SLEEP = 4'h6;
   // CTRL fields
   localparam int CTRL_CFD_EN = 0;
   localparam int CTRL_POR_EN = 1;
   localparam int CTRL_POR_MASK = 2;
   localparam int CTRL_SM_EN = 3;
   localparam int CTRL_MAIN_SEL = 4;
   localparam logic [7:0] CTRL_RST = 8'h03;
   // Divider fields: log2 factors
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_RATIO_MAX = 3'h2;
   // Oscillator fields
   localparam int OSC_EN = 0;
   localparam int OSC_MODE = 1;
   localparam logic OSC_MODE_EXT = 1'h0;
   // Status fields
   localparam int ST_CFD = 0;
   localparam int ST_HS_ON = 1;
   localparam int ST_OSC_ON = 2;
   localparam int ST_UNSTABLE = 3;
   // Reset cause codes
   localparam logic [7:0] CAUSE_POR = 8'h01;
   localparam logic [7:0] CAUSE_EXT = 8'h02;
   localparam logic [7:0] CAUSE_SLEEP = 8'h04;
   typedef enum logic [2:0] {
      SM_RUN = 3'h0,
      SM_IDLE = 3'h1,
      SM_FROZEN = 3'h2,
      SM_STANDBY = 3'h3,
      SM_STATIC = 3'h4,
      SM_SHUTDOWN = 3'h5
   } scrm_mode_t;
endpackage

// ==== hw/scrm_pb_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scrm_pb_if #(parameter int N = 4);
   logic [N-1:0] req;
   logic [N-1:0] mask;
   logic walk_gate;
   logic [N-1:0] en;
   modport mgr (output req, output mask, output walk_gate, input en);
   modport gate (input req, input mask, input walk_gate, output en);
endinterface
`default_nettype wire

// ==== hw/scrm_pb_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
module scrm_pb_gate #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Gate control
   scrm_pb_if.gate pb
);
   logic [N-1:0] en_q;
   logic [N-1:0] en_d;
   logic [N-1:0] walkers;

   always_comb begin
      walkers = pb.req & ~pb.mask;
      // During a wake walk only unmasked requesting peripherals keep their clocks; otherwise all stay on
      if (pb.walk_gate) begin
         en_d = walkers;
      end else begin
         en_d = {N{1'b1}};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         en_q <= {N{1'b1}};
      end else begin
         en_q <= en_d;
      end
   end

   assign pb.en = en_q;
endmodule
`default_nettype wire

// ==== sim/scrm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module scrm_chk (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Inputs watched
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_rst_evt,
   input wire logic i_por_evt,
   input wire logic i_clock_fail,
   input wire logic [3:0] i_pb_walk_req,
   // Outputs watched
   input wire logic [7:0] o_rdata,
   input wire logic o_hs_clk_on,
   input wire logic o_sel_system_rc_oscillator,
   input wire logic o_por_reset,
   input wire logic [3:0] o_pb_clk_en,
   input wire logic o_walk_unstable
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   property p_rd_idle;
      !$past(i_rd) |-> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_hs_off;
      $fell(o_hs_clk_on) |-> $past(i_wr) || $past(i_wr, 2);
   endproperty
   a_hs_off: assert property (p_hs_off) else $error("hs off");
   property p_por;
      o_por_reset |-> $past(i_por_evt);
   endproperty
   a_por: assert property (p_por) else $error("por no cause");
   property p_rc;
      $rose(o_sel_system_rc_oscillator) |->
         $past(i_clock_fail) || $past(i_wr) || $past(i_ext_rst_evt);
   endproperty
   a_rc: assert property (p_rc) else $error("rc no cause");
   property p_gate;
      $fell(&o_pb_clk_en) |->
         $past(|i_pb_walk_req) || $past(|i_pb_walk_req, 2);
   endproperty
   a_gate: assert property (p_gate) else $error("gate no req");
   property p_stick;
      o_walk_unstable && !i_wr && !i_ext_rst_evt |=> o_walk_unstable;
   endproperty
   a_stick: assert property (p_stick) else $error("flag lost");
   c_por: cover property (o_por_reset);
   c_hs: cover property (!o_hs_clk_on);
   c_uns: cover property (o_walk_unstable);
endmodule
bind scrm_top scrm_chk scrm_chk_inst (.i_clk_sys, .i_sys_rst, .i_wr, .i_rd,
   .i_ext_rst_evt, .i_por_evt, .i_clock_fail, .i_pb_walk_req, .o_rdata,
   .o_hs_clk_on, .o_sel_system_rc_oscillator, .o_por_reset, .o_pb_clk_en,
   .o_walk_unstable);
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic i_ext_rst_evt = 1'b0, i_por_evt = 1'b0, i_wake = 1'b0;
   logic i_debug_attached = 1'b0, i_clock_fail = 1'b0;
   logic [3:0] i_addr = 4'h0, i_pb_walk_req = 4'h0, o_pb_clk_en;
   logic [7:0] i_wdata = 8'h00, o_rdata, v;
   logic o_hs_clk_on, o_main_osc_on, o_sel_system_rc_oscillator;
   logic o_por_reset, o_walk_unstable;
   int errors = 0, n_checks = 0;
   scrm_top #(.N_PB(4)) scrm_top_inst (.i_clk_sys, .i_sys_rst, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_rst_evt, .i_por_evt, .i_wake,
      .i_debug_attached, .i_clock_fail, .i_pb_walk_req, .o_hs_clk_on,
      .o_main_osc_on, .o_sel_system_rc_oscillator, .o_por_reset,
      .o_pb_clk_en, .o_walk_unstable);
   initial forever #20 i_clk_sys = ~i_clk_sys;
   task automatic final_report();
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic wake();
      @(posedge i_clk_sys);
      i_wake <= 1'b1;
      i_pb_walk_req <= 4'h0;
      @(posedge i_clk_sys);
      i_wake <= 1'b0;
      tick(2);
   endtask
   task automatic t_reset();
      rd(scrm_pkg::ADDR_CTRL);
      chk(v, scrm_pkg::CTRL_RST);
      rd(4'hF);
      chk(v, 8'h00);
      chk(o_pb_clk_en, 8'h0F);
      chk(o_hs_clk_on, 8'h01);
      chk(o_main_osc_on, 8'h00);
      chk(o_sel_system_rc_oscillator, 8'h01);
      chk(o_por_reset, 8'h00);
      chk(o_walk_unstable, 8'h00);
   endtask
   task automatic t_ratio();
      for (int i = 0; i < 2; i++) begin
         wr(4'h1, i ? 8'h20 : 8'h30);
         wr(4'h6, 8'h04);
         tick(3);
         chk(o_hs_clk_on, i == 0);
         wake();
      end
      wr(4'h1, 8'h00);
   endtask
   task automatic t_cause();
      for (int i = 0; i < 2; i++) begin
         if (i == 0) wr(4'h6, 8'h05);
         @(posedge i_clk_sys);
         i_ext_rst_evt <= 1'b1;
         @(posedge i_clk_sys);
         i_ext_rst_evt <= 1'b0;
         rd(scrm_pkg::ADDR_CAUSE);
         chk(v, i ? scrm_pkg::CAUSE_EXT : scrm_pkg::CAUSE_POR);
      end
      wr(4'h6, 8'h05);
      wake();
      rd(scrm_pkg::ADDR_CAUSE);
      chk(v, scrm_pkg::CAUSE_SLEEP);
   endtask
   task automatic t_por();
      logic [7:0] c [4] = '{8'h06, 8'h04, 8'h0E, 8'h06};
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, c[i]);
         i_debug_attached <= (i == 3);
         wr(4'h6, i == 3 ? 8'h05 : 8'h00);
         @(posedge i_clk_sys);
         i_por_evt <= 1'b1;
         @(posedge i_clk_sys);
         i_por_evt <= 1'b0;
         #1 chk(o_por_reset, i != 0);
      end
      wake();
      i_debug_attached <= 1'b0;
   endtask
   task automatic t_cfd();
      for (int i = 0; i < 2; i++) begin
         wr(4'h4, 8'h01);
         wr(4'h0, 8'h13);
         tick(1);
         chk(o_sel_system_rc_oscillator, 8'h00);
         @(posedge i_clk_sys);
         i_clock_fail <= 1'b1;
         i_addr <= 4'h0;
         i_wdata <= 8'h12;
         i_wr <= (i == 1);
         @(posedge i_clk_sys);
         i_clock_fail <= 1'b0;
         i_wr <= 1'b0;
         tick(1);
         chk(o_sel_system_rc_oscillator, 8'h01);
         rd(4'h4);
         chk(v[scrm_pkg::ST_CFD], 8'h01);
      end
      wr(4'h0, 8'h02);
   endtask
   task automatic t_gate();
      for (int i = 0; i < 3; i++) begin
         wr(4'h3, i == 2 ? 8'h0F : 8'h00);
         wr(4'h6, i == 1 ? 8'h02 : 8'h01);
         i_pb_walk_req <= 4'h2;
         tick(3);
         chk(o_pb_clk_en, i == 2 ? 8'h0F : 8'h02);
         wake();
         chk(o_pb_clk_en, 8'h0F);
      end
      wr(4'h3, 8'h00);
   endtask
   task automatic t_osc();
      for (int i = 0; i < 2; i++) begin
         wr(4'h2, i ? 8'h01 : 8'h03);
         wr(4'h6, 8'h03);
         i_pb_walk_req <= 4'h1;
         tick(3);
         chk(o_main_osc_on, 8'h00);
         wake();
         chk(o_main_osc_on, 8'h01);
         chk(o_walk_unstable, 8'(i));
      end
      rd(4'h4);
      chk(v[scrm_pkg::ST_UNSTABLE], 8'h01);
      wr(4'h4, 8'h08);
      tick(1);
      chk(o_walk_unstable, 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      t_reset();
      t_ratio();
      t_cause();
      t_por();
      t_cfd();
      t_gate();
      t_osc();
      final_report();
   end
   initial begin
      #200us;
      errors++;
      final_report();
   end
endmodule
`default_nettype wire
